// [core/internal_routine_dispatch.sv]
// Notes on behaviour
// - call needs select bit 16 and entry
// - each routine has total and issue counts
// - coprocessor: host cycles are states halved
// - host-independent: one state per clock
// - host-independent accepts only mode 0 calls
// - modes 1, 2 count after operands arrive
// - add, subtract, compare: 2(1)
// - square roots take 20(19)
// - window compare 5(4), volume 7(6)
// - facing test takes 16(15)
// - line plane clips take 34(33)
// - color clips take 27(26)
// - viewport 56(55), interpolate 26(25)
// - spline 22(21), kernel filter 32(31)
// - abort stops running operation, 2(1)
// - check reports completion; vertex init 6(5)
// - series extremes 3(2) and 5(4)
// - polynomial and multiply-accumulate 4(3)
// - matrix steps 6(5), 10(9), 12(11)
// - ready low freezes state and outputs
`timescale 1ns/1ps
`include "ird_consts.svh"
module internal_routine_dispatch (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// call request from sequencer logic
	input wire logic call_valid,
	input wire logic [`ICS_BIT:0] call_word,
	input wire logic [1:0] call_mode,
	input wire logic operands_arrived,
	// device pins
	input wire logic ready_pin,
	input wire logic coproc_mode_pin,
	// status
	output logic issue_ready,
	output logic routine_active,
	output logic results_valid,
	output logic call_rejected,
	output logic op_aborted,
	output logic check_clear,
	output logic [`ENTRY_HI:0] active_entry,
	output logic [5:0] clock_cycles
);
	import ird_pkg::*;

	////////////////////////////////////////////////////////////////////
	// routine table

	// timing row builder
	function automatic routine_info_t row(input logic [11:0] ms, input routine_kind_t k);
		routine_info_t r;
		r.known = 1'b1;
		r.total = ms[11:6];
		r.issue = ms[5:0];
		r.kind = k;
		return r;
	endfunction : row

	// entry to timing, unlisted and transfer entries unknown
	function automatic routine_info_t lookup(input logic [`ENTRY_HI:0] e);
		routine_info_t r;
		r = '0;
		case (e)
			6'h00, 6'h01, 6'h02, 6'h03: r = row(`MS_BASIC, KIND_PLAIN);
			6'h08: r = row(`MS_BASIC, KIND_PLAIN);
			6'h09, 6'h0A: r = row(`MS_DIVIDE, KIND_PLAIN);
			6'h10: r = row(`MS_PWIN, KIND_PLAIN);
			6'h11: r = row(`MS_PVOL, KIND_PLAIN);
			6'h12: r = row(`MS_FACE, KIND_PLAIN);
			6'h13: r = row(`MS_BASIC, KIND_PLAIN);
			6'h14: r = row(`MS_INTERP, KIND_PLAIN);
			6'h15, 6'h16: r = row(`MS_LCLIP, KIND_PLAIN);
			6'h17, 6'h1C: r = row(`MS_CCLIP, KIND_PLAIN);
			6'h18: r = row(`MS_VIEWPORT, KIND_PLAIN);
			6'h19: r = row(`MS_TRANSPOSE, KIND_PLAIN);
			6'h1A: r = row(`MS_VERTEX, KIND_PLAIN);
			6'h1B: r = row(`MS_KERNEL, KIND_PLAIN);
			6'h1D: r = row(`MS_LINECMP, KIND_PLAIN);
			6'h1E: r = row(`MS_SPLINE, KIND_PLAIN);
			6'h20, 6'h21, 6'h22, 6'h23: r = row(`MS_BASIC, KIND_PLAIN);
			6'h27, 6'h28: r = row(`MS_CHAIN, KIND_PLAIN);
			6'h29, 6'h2A: r = row(`MS_ROOT, KIND_PLAIN);
			6'h2B: r = row(`MS_BASIC, KIND_ABORT);
			6'h2C: r = row(`MS_BASIC, KIND_PLAIN);
			6'h2D: r = row(`MS_BASIC, KIND_CHECK);
			6'h30, 6'h31: r = row(`MS_CHAIN, KIND_PLAIN);
			6'h32: r = row(`MS_EXT1, KIND_PLAIN);
			6'h33: r = row(`MS_EXT2, KIND_PLAIN);
			6'h34: r = row(`MS_MAT0, KIND_PLAIN);
			6'h35: r = row(`MS_MAT1, KIND_PLAIN);
			6'h36: r = row(`MS_MAT2, KIND_PLAIN);
			default: r = '0; // reserved entries stay unknown
		endcase
		return r;
	endfunction : lookup

	// select bit set and entry inside the integer page
	function automatic logic in_page(input logic [`ICS_BIT:0] w);
		return w[`ICS_BIT] && (w[`PAGE_HI:`ENTRY_HI+1] == '0)
			&& (w[`ENTRY_HI:0] <= `ENTRY_LAST);
	endfunction : in_page

	// a new call may be taken in this state and count
	function automatic logic may_issue(input seq_state_t s, input logic [5:0] c,
		input logic [5:0] i);
		return (s == ST_IDLE) || ((s == ST_RUN) && (c >= i));
	endfunction : may_issue

	////////////////////////////////////////////////////////////////////
	// pin synchronisers

	pin_sync_if sync_levels ();

	pin_sync u_pin_sync (
		.clock(clock),
		.resetn(resetn),
		.pins({coproc_mode_pin, ready_pin}),
		.levels(sync_levels.source)
	);

	logic ready_s;
	logic coproc_s;
	assign ready_s = sync_levels.ready_level;
	assign coproc_s = sync_levels.coproc_level;

	////////////////////////////////////////////////////////////////////
	// sequencer state

	seq_state_t state;
	seq_state_t next_state;
	logic [5:0] count;
	logic [5:0] next_count;
	logic [5:0] tail;
	logic [5:0] next_tail;
	logic [5:0] cur_total;
	logic [5:0] next_cur_total;
	logic [5:0] cur_issue;
	logic [5:0] next_cur_issue;
	routine_kind_t cur_kind;
	routine_kind_t next_cur_kind;
	logic next_issue_ready;
	logic next_routine_active;
	logic next_results_valid;
	logic next_call_rejected;
	logic next_op_aborted;
	logic next_check_clear;
	logic [`ENTRY_HI:0] next_active_entry;
	logic [5:0] next_clock_cycles;

	// table row for the presented entry
	routine_info_t info;
	assign info = lookup(call_word[`ENTRY_HI:0]);

	// legal call for the current mode
	logic mode_ok;
	logic legal;
	always_comb begin
		if (coproc_s) begin
			mode_ok = (call_mode != 2'h3);
		end else begin
			mode_ok = (call_mode == `XMODE_NONE);
		end
		legal = in_page(call_word) && info.known && mode_ok;
	end

	// next values of the sequencer
	always_comb begin
		logic can_take;
		logic finishing;
		logic prev_done;
		can_take = 1'b0;
		finishing = 1'b0;
		prev_done = 1'b0;
		next_state = state;
		next_count = count;
		next_tail = tail;
		next_cur_total = cur_total;
		next_cur_issue = cur_issue;
		next_cur_kind = cur_kind;
		next_issue_ready = issue_ready;
		next_routine_active = routine_active;
		next_results_valid = results_valid;
		next_call_rejected = call_rejected;
		next_op_aborted = op_aborted;
		next_check_clear = check_clear;
		next_active_entry = active_entry;
		next_clock_cycles = clock_cycles;
		// ready low: nothing moves, outputs hold
		if (ready_s) begin
			next_results_valid = 1'b0;
			next_call_rejected = 1'b0;
			next_op_aborted = 1'b0;
			// earlier routine still finishing after an overlapped issue
			if (tail != 6'h00) begin
				next_tail = tail - 6'h01;
				if (tail == 6'h01) begin
					next_results_valid = 1'b1;
				end
			end
			// next operation may begin once issue count elapsed
			can_take = may_issue(state, count, cur_issue);
			finishing = (state == ST_RUN) && (count + 6'h01 == cur_total);
			// a check taken while a routine winds up sees it unfinished
			prev_done = (state == ST_IDLE) && (tail == 6'h00);
			case (state)
				ST_IDLE: begin
					next_count = 6'h00;
				end
				ST_WAIT: begin
					// count starts once operands are
					if (operands_arrived) begin
						next_state = ST_RUN;
						next_count = 6'h00;
					end
				end
				ST_RUN: begin
					// one machine state per device clock
					next_count = count + 6'h01;
					if (finishing) begin
						next_results_valid = 1'b1;
						next_state = ST_IDLE;
					end
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
			if (call_valid && can_take) begin
				if (!legal) begin
					next_call_rejected = 1'b1;
				end else begin
					if (info.kind == KIND_ABORT) begin
						// running work is dropped, no result for it
						next_tail = 6'h00;
						next_results_valid = 1'b0;
						next_op_aborted = (state != ST_IDLE) || (tail != 6'h00);
					end else if ((state == ST_RUN) && !finishing) begin
						next_tail = cur_total - count - 6'h01;
					end
					if (info.kind == KIND_CHECK) begin
						next_check_clear = prev_done;
					end
					next_cur_total = info.total;
					next_cur_issue = info.issue;
					next_cur_kind = info.kind;
					next_active_entry = call_word[`ENTRY_HI:0];
					// host clocks are half the states in coprocessor mode
					next_clock_cycles = coproc_s ? (info.total >> 1) : info.total;
					next_count = 6'h00;
					if (call_mode == `XMODE_NONE) begin
						next_state = ST_RUN;
					end else begin
						next_state = ST_WAIT;
					end
				end
			end
			next_routine_active = (next_state != ST_IDLE) || (next_tail != 6'h00);
			next_issue_ready = may_issue(next_state, next_count, next_cur_issue);
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers

	// register the sequencer
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			count <= 6'h00;
			tail <= 6'h00;
			cur_total <= 6'h00;
			cur_issue <= 6'h00;
			cur_kind <= KIND_PLAIN;
			issue_ready <= 1'b1;
			routine_active <= 1'b0;
			results_valid <= 1'b0;
			call_rejected <= 1'b0;
			op_aborted <= 1'b0;
			check_clear <= 1'b1;
			active_entry <= 6'h00;
			clock_cycles <= 6'h00;
		end else begin
			state <= next_state;
			count <= next_count;
			tail <= next_tail;
			cur_total <= next_cur_total;
			cur_issue <= next_cur_issue;
			cur_kind <= next_cur_kind;
			issue_ready <= next_issue_ready;
			routine_active <= next_routine_active;
			results_valid <= next_results_valid;
			call_rejected <= next_call_rejected;
			op_aborted <= next_op_aborted;
			check_clear <= next_check_clear;
			active_entry <= next_active_entry;
			clock_cycles <= next_clock_cycles;
		end
	end
endmodule : internal_routine_dispatch

// [core/ird_consts.svh]
`ifndef IRD_CONSTS_SVH
`define IRD_CONSTS_SVH

// call word layout
`define ICS_BIT 16
`define PAGE_HI 15
`define ENTRY_HI 5
`define ENTRY_LAST 6'h36

// transfer modes
`define XMODE_NONE 2'h0
`define XMODE_OPER 2'h1
`define XMODE_MEM 2'h2

// machine states as {total, issue}
`define MS_BASIC {6'h02, 6'h01}
`define MS_DIVIDE {6'h10, 6'h0F}
`define MS_ROOT {6'h14, 6'h13}
`define MS_PWIN {6'h05, 6'h04}
`define MS_PVOL {6'h07, 6'h06}
`define MS_FACE {6'h10, 6'h0F}
`define MS_INTERP {6'h1A, 6'h19}
`define MS_LCLIP {6'h22, 6'h21}
`define MS_CCLIP {6'h1B, 6'h1A}
`define MS_VIEWPORT {6'h38, 6'h37}
`define MS_TRANSPOSE {6'h0D, 6'h0C}
`define MS_VERTEX {6'h06, 6'h05}
`define MS_KERNEL {6'h20, 6'h1F}
`define MS_LINECMP {6'h05, 6'h04}
`define MS_SPLINE {6'h16, 6'h15}
`define MS_CHAIN {6'h04, 6'h03}
`define MS_EXT1 {6'h03, 6'h02}
`define MS_EXT2 {6'h05, 6'h04}
`define MS_MAT0 {6'h06, 6'h05}
`define MS_MAT1 {6'h0A, 6'h09}
`define MS_MAT2 {6'h0C, 6'h0B}

`endif

// [core/ird_pkg.sv]
package ird_pkg;
	// dispatch sequencer states, gray along idle-wait-run
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1,
		ST_RUN = 2'h3
	} seq_state_t;

	// special handling of a routine
	typedef enum logic [1:0] {
		KIND_PLAIN = 2'h0,
		KIND_ABORT = 2'h1,
		KIND_CHECK = 2'h2
	} routine_kind_t;

	// one row of the routine table
	typedef struct packed {
		logic known;
		logic [5:0] total;
		logic [5:0] issue;
		routine_kind_t kind;
	} routine_info_t;
endpackage : ird_pkg

// [core/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// raw pins
	input wire logic [1:0] pins,
	// synchronised levels
	pin_sync_if.source levels
);
	import ird_pkg::*;

	logic [1:0] synced;

	// two flops per pin, first stage read only by the second
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sync
			logic first;
			logic second;
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					first <= 1'b0;
					second <= 1'b0;
				end else begin
					first <= pins[g];
					second <= first;
				end
			end
			assign synced[g] = second;
		end
	endgenerate

	assign levels.ready_level = synced[0];
	assign levels.coproc_level = synced[1];
endmodule : pin_sync

// [core/pin_sync_if.sv]
`timescale 1ns/1ps
// synchronised pin levels between sync stage and sequencer
interface pin_sync_if;
	logic ready_level;
	logic coproc_level;
	modport source (output ready_level, output coproc_level);
	modport sink (input ready_level, input coproc_level);
endinterface : pin_sync_if

// [testbench/host_issuer.sv]
`timescale 1ns/1ps
module host_issuer (
	// clock
	input wire logic clock,
	// device status
	input wire logic issue_ready,
	input wire logic coproc_mode_pin,
	// call group
	output logic call_valid,
	output logic [16:0] call_word,
	output logic [1:0] call_mode,
	output logic operands_arrived
);
	// idle bus at time zero
	initial begin
		call_valid = 1'b0;
		call_word = 17'h1FFFF;
		call_mode = 2'h3;
		operands_arrived = 1'b0;
	end
	// one call held until taken, then operand cycles
	task automatic issue(input logic [16:0] w, input logic [1:0] m, input int xtra);
		@(negedge clock);
		call_word = w;
		call_mode = m;
		call_valid = 1'b1;
		// settled level at the falling edge decides the next rising edge
		while (issue_ready !== 1'b1) @(negedge clock);
		@(negedge clock);
		call_valid = 1'b0;
		call_word = ~w;
		call_mode = ~m;
		if (m != 2'h0 && coproc_mode_pin) begin
			repeat (xtra) @(negedge clock);
			operands_arrived = 1'b1;
			@(negedge clock);
			operands_arrived = 1'b0;
		end
	endtask : issue
endmodule : host_issuer

// [testbench/internal_routine_dispatch_tb.sv]
`timescale 1ns/1ps
module internal_routine_dispatch_tb;
	logic clock, resetn, ready_pin, coproc_mode_pin, call_valid, operands_arrived;
	logic [16:0] call_word;
	logic [1:0] call_mode;
	logic issue_ready, routine_active, results_valid, call_rejected, op_aborted, check_clear;
	logic [5:0] active_entry, clock_cycles;
	int failures, total_checks, cycles;
	logic [5:0] ent [28] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h08, 6'h09, 6'h0A, 6'h10, 6'h11,
		6'h12, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h1B, 6'h1C, 6'h1E, 6'h29, 6'h2A, 6'h2C,
		6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h36};
	logic [5:0] tot [28] = '{6'h02, 6'h02, 6'h02, 6'h02, 6'h02, 6'h10, 6'h10, 6'h05, 6'h07,
		6'h10, 6'h1A, 6'h22, 6'h22, 6'h1B, 6'h38, 6'h20, 6'h1B, 6'h16, 6'h14, 6'h14, 6'h02,
		6'h04, 6'h04, 6'h03, 6'h05, 6'h06, 6'h0A, 6'h0C};
	logic [16:0] bw [8] = '{17'h00010, 17'h10004, 17'h1001F, 17'h10025, 17'h10037,
		17'h10410, 17'h10010, 17'h10010};
	logic [1:0] bm [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
	////////////////////////////////////////////////////////////////
	internal_routine_dispatch u_dut (.clock, .resetn, .call_valid, .call_word, .call_mode,
		.operands_arrived, .ready_pin, .coproc_mode_pin, .issue_ready, .routine_active,
		.results_valid, .call_rejected, .op_aborted, .check_clear, .active_entry, .clock_cycles);
	host_issuer u_host (.clock, .issue_ready, .coproc_mode_pin, .call_valid, .call_word,
		.call_mode, .operands_arrived);
	// clock source
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////
	function automatic logic diff(input logic d);
		total_checks++;
		return d;
	endfunction : diff
	task automatic bad(input string msg);
		$display("mismatch at %0t: %s", $time, msg);
		failures++;
	endtask : bad
	task automatic end_of_test();
		if (failures == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	// count states to issue and results, with an optional stall
	task automatic run_count(input int st, output int ni, output int nr);
		ni = 0;
		nr = 0;
		while (results_valid !== 1'b1 && nr < 90) begin
			if (ni == 0 && issue_ready === 1'b1) ni = nr;
			if (nr == 5 && st > 0) begin
				ready_pin = 1'b0;
				repeat (st) @(negedge clock);
				ready_pin = 1'b1;
				nr += st;
			end
			@(negedge clock);
			nr++;
		end
	endtask : run_count
	// one accepted call judged on its timing
	task automatic one(input logic [16:0] w, input logic [1:0] m, input int x, input int st,
		input logic [5:0] t, input logic [5:0] cyc);
		int ni;
		int nr;
		u_host.issue(w, m, x);
		run_count(st, ni, nr);
		if (diff(nr != t + st)) bad("total states");
		if (m == 2'h0 && diff(ni != t - 1 + st)) bad("issue states");
		if (diff(clock_cycles !== cyc)) bad("cycle figure");
		if (diff(active_entry !== w[5:0])) bad("entry");
		while (routine_active === 1'b1) @(negedge clock);
	endtask : one
	////////////////////////////////////////////////////////////////
	task automatic t_refuse();
		for (int i = 0; i < 8; i++) begin
			u_host.issue(bw[i], bm[i], 0);
			if (diff(call_rejected !== 1'b1)) bad("no reject");
			if (diff(routine_active !== 1'b0)) bad("started");
			@(negedge clock);
		end
	endtask : t_refuse
	task automatic t_check_abort();
		u_host.issue(17'h10009, 2'h0, 0);
		u_host.issue(17'h1002D, 2'h0, 0);
		if (diff(check_clear !== 1'b0)) bad("check early");
		while (routine_active === 1'b1) @(negedge clock);
		u_host.issue(17'h1002D, 2'h0, 0);
		if (diff(check_clear !== 1'b1)) bad("check late");
		u_host.issue(17'h10018, 2'h0, 0);
		u_host.issue(17'h1002B, 2'h0, 0);
		if (diff(op_aborted !== 1'b1)) bad("abort busy");
		while (routine_active === 1'b1) @(negedge clock);
		u_host.issue(17'h1002B, 2'h0, 0);
		if (diff(op_aborted !== 1'b0)) bad("abort idle");
		while (routine_active === 1'b1) @(negedge clock);
	endtask : t_check_abort
	////////////////////////////////////////////////////////////////
	// cycle ceiling
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			bad("timeout");
			end_of_test();
		end
	end
	// main sequence
	initial begin
		failures = 0;
		total_checks = 0;
		cycles = 0;
		resetn = 1'b0;
		ready_pin = 1'b1;
		coproc_mode_pin = 1'b0;
		repeat (16) @(negedge clock);
		resetn = 1'b1;
		repeat (3) @(negedge clock);
		for (int i = 0; i < 28; i++) begin
			one({11'h400, ent[i]}, 2'h0, 0, 0, tot[i], tot[i]);
		end
		t_refuse(); // bad calls, each checked for reject and no start
		t_check_abort();
		one(17'h1002A, 2'h0, 0, 10, 6'h14, 6'h14);
		coproc_mode_pin = 1'b1;
		repeat (4) @(negedge clock);
		one(17'h10009, 2'h0, 0, 0, 6'h10, 6'h08);
		one(17'h10010, 2'h1, 1, 0, 6'h05, 6'h02);
		one(17'h10018, 2'h2, 4, 0, 6'h38, 6'h1C);
		end_of_test();
	end
endmodule : internal_routine_dispatch_tb

// [testbench/ird_props.sv]
`timescale 1ns/1ps
module ird_props (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// call and pins
	input wire logic call_valid,
	input wire logic [16:0] call_word,
	input wire logic [1:0] call_mode,
	input wire logic ready_pin,
	input wire logic coproc_mode_pin,
	// status
	input wire logic issue_ready,
	input wire logic routine_active,
	input wire logic results_valid,
	input wire logic call_rejected,
	input wire logic op_aborted,
	input wire logic [5:0] active_entry,
	input wire logic [5:0] clock_cycles
);
	logic [3:0] rd_hist;
	logic [3:0] cp_hist;
	logic hacc;
	logic cacc;
	////////////////////////////////////////////////////////////////
	// pin history covers the synchroniser delay
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rd_hist <= 4'h0;
			cp_hist <= 4'h0;
		end else begin
			rd_hist <= {rd_hist[2:0], ready_pin};
			cp_hist <= {cp_hist[2:0], coproc_mode_pin};
		end
	end
	// calls taken in each mode with pins settled
	assign hacc = rd_hist == 4'hF && cp_hist == 4'h0 && call_valid && issue_ready;
	assign cacc = rd_hist == 4'hF && cp_hist == 4'hF && call_valid && issue_ready;
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	a_win_time: assert property (hacc && call_word == 17'h10010 && call_mode == 2'h0
		|=> active_entry == 6'h10 && clock_cycles == 6'h05 ##0 (!issue_ready) [*4]
		##1 issue_ready ##1 results_valid) else $error("window compare timing");
	a_div_time: assert property (hacc && call_word == 17'h10009 && call_mode == 2'h0
		|-> ##16 issue_ready ##1 results_valid) else $error("divide timing");
	a_root_time: assert property (hacc && call_word == 17'h10029 && call_mode == 2'h0
		|-> ##20 issue_ready ##1 results_valid) else $error("root timing");
	a_basic_pair: assert property (hacc && call_word[16:2] == 15'h4000 && call_mode == 2'h0
		|=> ##1 issue_ready ##1 results_valid) else $error("basic timing");
	a_bad_refused: assert property (hacc && (!call_word[16] || call_word[15:0] inside
		{16'h0004, 16'h0005, 16'h000B, 16'h000C, 16'h000F, 16'h001F, 16'h0024, 16'h0025,
		16'h0026}) |=> call_rejected && active_entry == $past(active_entry))
		else $error("unused entry accepted");
	a_host_mode0: assert property (hacc && call_mode != 2'h0 |=> call_rejected)
		else $error("transfer call accepted");
	a_coproc_half: assert property (cacc && call_word == 17'h10018 && call_mode != 2'h3
		|=> clock_cycles == 6'h1C) else $error("host cycle figure");
	a_stall_hold: assert property (rd_hist == 4'h0 && !ready_pin
		|=> $stable({issue_ready, routine_active, results_valid, active_entry, clock_cycles}))
		else $error("outputs moved while stalled");
	a_abort_flag: assert property (hacc && call_word == 17'h1002B && routine_active
		|=> op_aborted) else $error("abort not flagged");
	// main scenarios
	c_host_call: cover property (hacc && !routine_active);
	c_coproc_call: cover property (cacc);
	c_reject: cover property (call_rejected);
endmodule : ird_props

bind internal_routine_dispatch ird_props u_props (.clock, .resetn, .call_valid, .call_word,
	.call_mode, .ready_pin, .coproc_mode_pin, .issue_ready, .routine_active, .results_valid,
	.call_rejected, .op_aborted, .active_entry, .clock_cycles);
